// file: rtl/rsc_reset_ctrl.sv
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module rsc_reset_ctrl
    import rsc_pkg::*;
#(
    parameter int WDT_CYCLES = 20000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // reset pin, active low, asynchronous
    input wire logic reset_pin_n_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // clock control
    output logic cpu_clk_en_o,
    output logic osc_main_en_o,
    output logic osc_sub_en_o,
    output logic osc_hs_en_o,
    output logic osc_ls_en_o,
    output logic ext_clk_accept_o,
    output logic osc_pins_port_mode_o,
    output logic cpu_clk_src_o,
    // processor start
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic reset_active_o,
    // port, memory size and trim configuration
    output logic [NPORT*8-1:0] port_output_latch_o,
    output logic [NPORT*8-1:0] port_direction_o,
    output logic [NPORT*8-1:0] port_pullup_option_o,
    output logic [7:0] int_memory_size_sel_o,
    output logic [7:0] exp_ram_size_sel_o,
    output logic [7:0] hs_osc_trim_o
);
    ////////////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic in_group(input logic [ADR_W-1:0] a, input logic [7:0] base, input int n);
        in_group = (a >= base) && (a < base + 8'(n * 4)) && (a[1:0] == 2'b00);
    endfunction

    function automatic int group_idx(input logic [ADR_W-1:0] a, input logic [7:0] base);
        group_idx = int'((a - base) >> 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset sources and reset sequencing

    logic pin_sync;
    logic wdt_ovf;
    logic reset_req;
    logic hold;
    logic reset_active_q;
    logic [3:0] proc_cnt_q;
    logic wdt_cause_q;
    logic wdt_en_q;
    logic wdt_kick;
    logic wr;
    logic [ADR_W-1:0] adr;
    logic [7:0] wbyte;

    rsc_sync2 u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(reset_pin_n_i),
        .q_o(pin_sync)
    );

    // pulse width is the driver's job; any synced low level is taken
    assign reset_req = rst_i || !pin_sync || wdt_ovf;
    assign hold = reset_req || reset_active_q;

    always_ff @(posedge clk_i) begin
        if (reset_req) begin
            reset_active_q <= 1'b1;
            proc_cnt_q <= 4'h0;
        end else if (reset_active_q) begin
            if (proc_cnt_q == 4'(RESET_PROC_CYCLES - 1)) begin
                reset_active_q <= 1'b0;
            end
            proc_cnt_q <= proc_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !pin_sync) begin
            wdt_cause_q <= 1'b0;
        end else if (wdt_ovf) begin
            wdt_cause_q <= 1'b1;
        end
    end

    assign reset_active_o = reset_active_q;

    // watchdog sits in the reset domain it triggers, so its own overflow clears it
    rsc_wdt #(
        .WDT_CYCLES(WDT_CYCLES)
    ) u_wdt (
        .clk_i(clk_i),
        .rst_i(hold),
        .enable_i(wdt_en_q),
        .kick_i(wdt_kick),
        .overflow_o(wdt_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus write path

    assign adr = wb_adr_i;
    // write lands at the ack edge, the one edge the master samples
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && !hold;
    assign wbyte = wb_dat_i[7:0];
    assign wdt_kick = wr && (adr == OFS_WDT_CTRL) && wbyte[WDT_KICK_BIT];

    always_ff @(posedge clk_i) begin
        if (hold) begin
            wdt_en_q <= 1'b0;
        end else if (wr && adr == OFS_WDT_CTRL) begin
            wdt_en_q <= wbyte[WDT_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port registers

    logic [7:0] latch_q [NPORT];
    logic [7:0] dir_q [NPORT];
    logic [7:0] pullup_q [NPORT];

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        always_ff @(posedge clk_i) begin
            if (hold) begin
                latch_q[p] <= RST_PORT_LATCH;
                dir_q[p] <= RST_PORT_DIR;
                pullup_q[p] <= RST_PORT_PULLUP;
            end else if (wr) begin
                if (adr == OFS_PORT_LATCH + 8'(p * 4)) begin
                    latch_q[p] <= wbyte;
                end
                if (adr == OFS_PORT_DIR + 8'(p * 4)) begin
                    dir_q[p] <= wbyte;
                end
                if (adr == OFS_PORT_PULLUP + 8'(p * 4)) begin
                    pullup_q[p] <= wbyte;
                end
            end
        end
        assign port_output_latch_o[p*8 +: 8] = latch_q[p];
        assign port_direction_o[p*8 +: 8] = dir_q[p];
        assign port_pullup_option_o[p*8 +: 8] = pullup_q[p];
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory size, clock and oscillator registers

    logic [7:0] mem_size_q;
    logic [7:0] xram_size_q;
    logic [7:0] clk_mode_q;
    logic [7:0] ostab_status_q;
    logic [7:0] ostab_time_q;
    logic [7:0] trim_q;
    logic [6:0] ostab_div_q;

    // memory size is fixed at reset whatever is fitted; software sets the real one
    always_ff @(posedge clk_i) begin
        if (hold) begin
            mem_size_q <= RST_MEM_SIZE;
            xram_size_q <= RST_XRAM_SIZE;
        end else if (wr) begin
            if (adr == OFS_MEM_SIZE) begin
                mem_size_q <= wbyte;
            end
            if (adr == OFS_XRAM_SIZE) begin
                xram_size_q <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold) begin
            clk_mode_q <= RST_CLK_MODE;
            ostab_time_q <= RST_OSTAB_TIME;
            trim_q <= RST_HS_TRIM;
        end else if (wr) begin
            if (adr == OFS_CLK_MODE) begin
                clk_mode_q <= wbyte;
            end
            if (adr == OFS_OSTAB_TIME) begin
                ostab_time_q <= wbyte;
            end
            if (adr == OFS_HS_TRIM) begin
                trim_q <= wbyte;
            end
        end
    end

    // status fills with ones from the top while the main oscillator settles
    always_ff @(posedge clk_i) begin
        if (hold || !clk_mode_q[CLKM_MAIN_EN]) begin
            ostab_status_q <= RST_OSTAB_STATUS;
            ostab_div_q <= 7'h00;
        end else if (ostab_div_q == 7'(OSC_STAB_STEP - 1)) begin
            ostab_div_q <= 7'h00;
            ostab_status_q <= {1'b1, ostab_status_q[7:1]};
        end else begin
            ostab_div_q <= ostab_div_q + 7'h01;
        end
    end

    assign int_memory_size_sel_o = mem_size_q;
    assign exp_ram_size_sel_o = xram_size_q;
    assign hs_osc_trim_o = trim_q;

    ////////////////////////////////////////////////////////////////////////////
    // 16-bit timer/event counter

    logic [15:0] t16_cnt_q;
    logic [15:0] t16_cca_q;
    logic [15:0] t16_ccb_q;
    logic [7:0] t16_mode_q;
    logic [7:0] t16_presc_q;
    logic [7:0] t16_ccctrl_q;
    logic [7:0] t16_outctrl_q;

    always_ff @(posedge clk_i) begin
        if (hold) begin
            t16_cnt_q <= RST_T16;
        end else if (t16_mode_q[T16_RUN_BIT] && t16_cnt_q == t16_cca_q) begin
            t16_cnt_q <= RST_T16;
        end else if (t16_mode_q[T16_RUN_BIT]) begin
            t16_cnt_q <= t16_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold) begin
            t16_cca_q <= RST_T16;
            t16_ccb_q <= RST_T16;
            t16_mode_q <= RST_BYTE0;
            t16_presc_q <= RST_BYTE0;
            t16_ccctrl_q <= RST_BYTE0;
            t16_outctrl_q <= RST_BYTE0;
        end else if (wr) begin
            if (adr == OFS_T16_CCA) begin
                t16_cca_q <= wb_dat_i[15:0];
            end
            if (adr == OFS_T16_CCB) begin
                t16_ccb_q <= wb_dat_i[15:0];
            end
            if (adr == OFS_T16_MODE) begin
                t16_mode_q <= wbyte;
            end
            if (adr == OFS_T16_PRESC) begin
                t16_presc_q <= wbyte;
            end
            if (adr == OFS_T16_CCCTRL) begin
                t16_ccctrl_q <= wbyte;
            end
            if (adr == OFS_T16_OUTCTRL) begin
                t16_outctrl_q <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 8-bit timer/event counters, four words each

    logic [7:0] t8_cnt_q [NTIM8];
    logic [7:0] t8_cmp_q [NTIM8];
    logic [7:0] t8_clk_q [NTIM8];
    logic [7:0] t8_mode_q [NTIM8];

    for (genvar t = 0; t < NTIM8; t++) begin : g_t8
        localparam logic [7:0] BASE = OFS_T8_BASE + 8'(t * 16);
        always_ff @(posedge clk_i) begin
            if (hold) begin
                t8_cnt_q[t] <= RST_T8;
            end else if (t8_mode_q[t][T8_RUN_BIT] && t8_cnt_q[t] == t8_cmp_q[t]) begin
                t8_cnt_q[t] <= RST_T8;
            end else if (t8_mode_q[t][T8_RUN_BIT]) begin
                t8_cnt_q[t] <= t8_cnt_q[t] + 8'h01;
            end
        end
        always_ff @(posedge clk_i) begin
            if (hold) begin
                t8_cmp_q[t] <= RST_T8;
                t8_clk_q[t] <= RST_T8;
                t8_mode_q[t] <= RST_T8;
            end else if (wr) begin
                if (adr == BASE + 8'h04) begin
                    t8_cmp_q[t] <= wbyte;
                end
                if (adr == BASE + 8'h08) begin
                    t8_clk_q[t] <= wbyte;
                end
                if (adr == BASE + 8'h0C) begin
                    t8_mode_q[t] <= wbyte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset vector and program counter load

    logic [7:0] vec_lo_q;
    logic [7:0] vec_hi_q;
    logic active_d1_q;

    // vector bytes model nonvolatile words: only a full system reset clears them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_lo_q <= RST_BYTE0;
            vec_hi_q <= RST_BYTE0;
        end else if (wr) begin
            if (adr == OFS_VEC_LO) begin
                vec_lo_q <= wbyte;
            end
            if (adr == OFS_VEC_HI) begin
                vec_hi_q <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_d1_q <= 1'b1;
            pc_o <= 16'h0000;
            pc_load_o <= 1'b0;
        end else begin
            active_d1_q <= reset_active_q;
            pc_load_o <= active_d1_q && !reset_active_q;
            if (active_d1_q && !reset_active_q) begin
                pc_o <= {vec_hi_q, vec_lo_q};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock gating and oscillator control

    always_ff @(posedge clk_i) begin
        if (hold) begin
            cpu_clk_en_o <= 1'b0;
            osc_main_en_o <= 1'b0;
            osc_sub_en_o <= 1'b0;
            osc_hs_en_o <= 1'b0;
            osc_ls_en_o <= 1'b0;
            ext_clk_accept_o <= 1'b0;
            osc_pins_port_mode_o <= 1'b1;
            cpu_clk_src_o <= 1'(RSC_SRC_HS);
        end else begin
            cpu_clk_en_o <= !active_d1_q;
            osc_hs_en_o <= 1'b1;
            osc_main_en_o <= clk_mode_q[CLKM_MAIN_EN] && !clk_mode_q[CLKM_EXT_CLK];
            osc_sub_en_o <= clk_mode_q[CLKM_SUB_EN];
            osc_ls_en_o <= !clk_mode_q[CLKM_LS_STOP];
            ext_clk_accept_o <= clk_mode_q[CLKM_MAIN_EN] && clk_mode_q[CLKM_EXT_CLK];
            osc_pins_port_mode_o <= !clk_mode_q[CLKM_MAIN_EN];
            // switching to main clock waits for the full stabilization count
            cpu_clk_src_o <= 1'((clk_mode_q[CLKM_MAIN_SEL] && ostab_status_q[0]) ? RSC_SRC_MAIN : RSC_SRC_HS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus read path and acknowledge

    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h00000000;
        if (in_group(adr, OFS_PORT_LATCH, NPORT)) begin
            rdata[7:0] = latch_q[group_idx(adr, OFS_PORT_LATCH)];
        end else if (in_group(adr, OFS_PORT_DIR, NPORT)) begin
            rdata[7:0] = dir_q[group_idx(adr, OFS_PORT_DIR)];
        end else if (in_group(adr, OFS_PORT_PULLUP, NPORT)) begin
            rdata[7:0] = pullup_q[group_idx(adr, OFS_PORT_PULLUP)];
        end else if (in_group(adr, OFS_T8_BASE, NTIM8 * 4)) begin
            unique case (adr[3:2])
                2'h0: rdata[7:0] = t8_cnt_q[group_idx(adr, OFS_T8_BASE) / 4];
                2'h1: rdata[7:0] = t8_cmp_q[group_idx(adr, OFS_T8_BASE) / 4];
                2'h2: rdata[7:0] = t8_clk_q[group_idx(adr, OFS_T8_BASE) / 4];
                2'h3: rdata[7:0] = t8_mode_q[group_idx(adr, OFS_T8_BASE) / 4];
            endcase
        end else begin
            unique case (adr)
                OFS_MEM_SIZE: rdata[7:0] = mem_size_q;
                OFS_XRAM_SIZE: rdata[7:0] = xram_size_q;
                OFS_CLK_MODE: rdata[7:0] = clk_mode_q;
                OFS_OSTAB_STATUS: rdata[7:0] = ostab_status_q;
                OFS_OSTAB_TIME: rdata[7:0] = ostab_time_q;
                OFS_HS_TRIM: rdata[7:0] = trim_q;
                OFS_T16_COUNT: rdata[15:0] = t16_cnt_q;
                OFS_T16_CCA: rdata[15:0] = t16_cca_q;
                OFS_T16_CCB: rdata[15:0] = t16_ccb_q;
                OFS_T16_MODE: rdata[7:0] = t16_mode_q;
                OFS_T16_PRESC: rdata[7:0] = t16_presc_q;
                OFS_T16_CCCTRL: rdata[7:0] = t16_ccctrl_q;
                OFS_T16_OUTCTRL: rdata[7:0] = t16_outctrl_q;
                OFS_VEC_LO: rdata[7:0] = vec_lo_q;
                OFS_VEC_HI: rdata[7:0] = vec_hi_q;
                OFS_WDT_CTRL: rdata[WDT_EN_BIT] = wdt_en_q;
                OFS_STATUS: rdata[2:0] = {cpu_clk_src_o, wdt_cause_q, reset_active_q};
                default: rdata = 32'h00000000;
            endcase
        end
    end

    // one wait state; unmapped addresses read zero and still acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rdata;
        end
    end
endmodule

// file: rtl/rsc_pkg.sv
package rsc_pkg;
    // sizes of the block
    localparam int NPORT = 4;
    localparam int NTIM8 = 3;
    localparam int ADR_W = 8;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int RESET_PROC_CYCLES = 8;
    localparam int OSC_STAB_STEP = 64;

    // register byte offsets
    localparam logic [7:0] OFS_PORT_LATCH = 8'h00;
    localparam logic [7:0] OFS_PORT_DIR = 8'h10;
    localparam logic [7:0] OFS_PORT_PULLUP = 8'h20;
    localparam logic [7:0] OFS_MEM_SIZE = 8'h30;
    localparam logic [7:0] OFS_XRAM_SIZE = 8'h34;
    localparam logic [7:0] OFS_CLK_MODE = 8'h38;
    localparam logic [7:0] OFS_OSTAB_STATUS = 8'h3C;
    localparam logic [7:0] OFS_OSTAB_TIME = 8'h40;
    localparam logic [7:0] OFS_HS_TRIM = 8'h44;
    localparam logic [7:0] OFS_T16_COUNT = 8'h48;
    localparam logic [7:0] OFS_T16_CCA = 8'h4C;
    localparam logic [7:0] OFS_T16_CCB = 8'h50;
    localparam logic [7:0] OFS_T16_MODE = 8'h54;
    localparam logic [7:0] OFS_T16_PRESC = 8'h58;
    localparam logic [7:0] OFS_T16_CCCTRL = 8'h5C;
    localparam logic [7:0] OFS_T16_OUTCTRL = 8'h60;
    localparam logic [7:0] OFS_T8_BASE = 8'h80;
    localparam logic [7:0] OFS_VEC_LO = 8'hC0;
    localparam logic [7:0] OFS_VEC_HI = 8'hC4;
    localparam logic [7:0] OFS_WDT_CTRL = 8'hC8;
    localparam logic [7:0] OFS_STATUS = 8'hCC;

    // reset values
    localparam logic [7:0] RST_PORT_LATCH = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_PORT_PULLUP = 8'h00;
    localparam logic [7:0] RST_MEM_SIZE = 8'hCF;
    localparam logic [7:0] RST_XRAM_SIZE = 8'h0C;
    localparam logic [7:0] RST_CLK_MODE = 8'h00;
    localparam logic [7:0] RST_OSTAB_STATUS = 8'h00;
    localparam logic [7:0] RST_OSTAB_TIME = 8'h05;
    localparam logic [7:0] RST_HS_TRIM = 8'h10;
    localparam logic [15:0] RST_T16 = 16'h0000;
    localparam logic [7:0] RST_T8 = 8'h00;
    localparam logic [7:0] RST_BYTE0 = 8'h00;

    // field positions
    localparam int CLKM_MAIN_SEL = 0;
    localparam int CLKM_EXT_CLK = 5;
    localparam int CLKM_MAIN_EN = 6;
    localparam int CLKM_SUB_EN = 4;
    localparam int CLKM_LS_STOP = 7;
    localparam int T16_RUN_BIT = 2;
    localparam int T8_RUN_BIT = 7;
    localparam int WDT_EN_BIT = 0;
    localparam int WDT_KICK_BIT = 1;

    typedef enum logic [1:0] {RSC_SRC_HS, RSC_SRC_MAIN} rsc_clk_src_type;
endpackage

// file: rtl/rsc_sync2.sv
`timescale 1ns/100ps
module rsc_sync2 (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level crossing
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    // both stages set to the idle-high pin level, so reset does not look like a pin pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// file: rtl/rsc_wdt.sv
`timescale 1ns/100ps
module rsc_wdt #(
    parameter int WDT_CYCLES = 20000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic kick_i,
    // overflow event
    output logic overflow_o
);
    logic [31:0] count_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || kick_i || !enable_i) begin
            count_q <= 32'h00000000;
        end else if (count_q != 32'(WDT_CYCLES - 1)) begin
            count_q <= count_q + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= enable_i && !kick_i && (count_q == 32'(WDT_CYCLES - 2));
        end
    end
endmodule

// file: testbench/rsc_reset_ctrl_properties.sv
`timescale 1ns/100ps
module rsc_reset_ctrl_properties
    import rsc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // clocks and start
    input wire logic cpu_clk_en_o,
    input wire logic osc_main_en_o,
    input wire logic osc_sub_en_o,
    input wire logic osc_hs_en_o,
    input wire logic osc_ls_en_o,
    input wire logic ext_clk_accept_o,
    input wire logic osc_pins_port_mode_o,
    input wire logic cpu_clk_src_o,
    input wire logic pc_load_o,
    input wire logic reset_active_o,
    // configuration
    input wire logic [NPORT*8-1:0] port_output_latch_o,
    input wire logic [NPORT*8-1:0] port_direction_o,
    input wire logic [NPORT*8-1:0] port_pullup_option_o,
    input wire logic [7:0] int_memory_size_sel_o,
    input wire logic [7:0] exp_ram_size_sel_o,
    input wire logic [7:0] hs_osc_trim_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_clk_gated: assert property (reset_active_o |-> !cpu_clk_en_o)
    else $error("cpu clock runs in reset");
a_osc_halted: assert property (reset_active_o |-> !(osc_main_en_o | osc_sub_en_o | osc_hs_en_o | osc_ls_en_o))
    else $error("oscillator runs in reset");
a_extclk_off: assert property (reset_active_o |-> !ext_clk_accept_o && osc_pins_port_mode_o)
    else $error("external clock taken in reset");
a_pc_start: assert property ($fell(reset_active_o) |=> pc_load_o ##1 (cpu_clk_en_o && !pc_load_o))
    else $error("start sequence wrong");
a_ports_init: assert property (reset_active_o |->
    port_output_latch_o == '0 && port_direction_o == '1 && port_pullup_option_o == '0)
    else $error("port defaults wrong");
a_mem_init: assert property (reset_active_o |->
    int_memory_size_sel_o == 8'hCF && exp_ram_size_sel_o == 8'h0C && hs_osc_trim_o == 8'h10)
    else $error("memory or trim defaults wrong");
a_hs_start: assert property (pc_load_o |-> !cpu_clk_src_o && osc_hs_en_o)
    else $error("start not from high-speed oscillator");
a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_properties rsc_reset_ctrl_properties_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .cpu_clk_en_o, .osc_main_en_o, .osc_sub_en_o, .osc_hs_en_o, .osc_ls_en_o, .ext_clk_accept_o,
    .osc_pins_port_mode_o, .cpu_clk_src_o, .pc_load_o, .reset_active_o, .port_output_latch_o, .port_direction_o,
    .port_pullup_option_o, .int_memory_size_sel_o, .exp_ram_size_sel_o, .hs_osc_trim_o);

// file: testbench/rsc_pin_model.sv
`timescale 1ns/100ps
module rsc_pin_model (
    // clock and command
    input wire logic clk_i,
    input wire logic go_i,
    // reset pin, pulled up when released
    output logic reset_pin_n_o
);
int cnt = 0;
always @(posedge clk_i) begin
    if (go_i && cnt == 0) begin
        cnt <= 1000;
    end else if (cnt != 0) begin
        cnt <= cnt - 1;
    end
end
assign reset_pin_n_o = (cnt == 0);
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
import rsc_pkg::*;
logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, pin_n;
logic [7:0] adr = 0;
logic [31:0] dat = 0, q, rnd = 32'haec752de;
logic [31:0] wr [logic [7:0]];
logic [7:0] regs [$];
logic [15:0] vec;
logic [31:0] wb_dat_o;
logic wb_ack_o, reset_active_o, pc_load_o;
logic [15:0] pc_o;
int err_total = 0, n_compared = 0;
initial begin
    forever #5 clk_i = ~clk_i;
end
rsc_pin_model rsc_pin_model_i (.clk_i(clk_i), .go_i(go), .reset_pin_n_o(pin_n));
rsc_reset_ctrl #(.WDT_CYCLES(40)) rsc_reset_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_clk_en_o(), .osc_main_en_o(), .osc_sub_en_o(),
    .osc_hs_en_o(), .osc_ls_en_o(), .ext_clk_accept_o(), .osc_pins_port_mode_o(), .cpu_clk_src_o(),
    .pc_o(pc_o), .pc_load_o(pc_load_o), .reset_active_o(reset_active_o), .port_output_latch_o(),
    .port_direction_o(), .port_pullup_option_o(), .int_memory_size_sel_o(), .exp_ram_size_sel_o(),
    .hs_osc_trim_o());
////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
endfunction
function automatic logic [31:0] exp_rst(input logic [7:0] a);
    if (a < 8'h10) return 32'h00;
    if (a < 8'h20) return 32'hFF;
    case (a)
        8'h30: return 32'hCF;
        8'h34: return 32'h0C;
        8'h40: return 32'h05;
        8'h44: return 32'h10;
        default: return 32'h00;
    endcase
endfunction
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    // no own limit: only the watchdog process ends a hung wait
    do begin
        @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 0;
    stb <= 0;
endtask
// waits out reset processing and checks the start address
task automatic wait_run(input logic [15:0] exp);
    int n = 0;
    while (reset_active_o !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
    while (reset_active_o !== 1'b0 && n < 3000) begin @(posedge clk_i); n++; end
    @(posedge clk_i);
    chk({pc_load_o, pc_o}, {1'b1, exp});
endtask
task automatic chk_defaults;
    foreach (regs[i]) begin
        wb(0, regs[i], 0);
        chk(q, exp_rst(regs[i]));
    end
endtask
task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    #200000;
    err_total++;
    results();
end
initial begin
    for (int i = 0; i < 37; i++) regs.push_back(i < 25 ? 8'(4 * i) : 8'(8'h80 + 4 * (i - 25)));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    wait_run(16'h0000);
    chk_defaults();
    wb(0, 8'hFC, 0);
    chk(q, 0);
    wb(1, 8'h3C, 32'hFF);
    wb(0, 8'h3C, 0);
    chk(q, 0);
    // clock mode, oscillator status and counters excluded: status and counters do not read back what was written
    foreach (regs[i]) begin
        if (regs[i] inside {8'h38, 8'h3C, 8'h48} || (regs[i] >= 8'h80 && regs[i][3:0] == 4'h0)) continue;
        rnd = xs(rnd);
        wr[regs[i]] = {16'h0, (regs[i] inside {8'h4C, 8'h50}) ? rnd[15:8] : 8'h00, rnd[7:0]};
        wb(1, regs[i], wr[regs[i]]);
    end
    foreach (wr[a]) begin
        wb(0, a, 0);
        chk(q, wr[a]);
    end
    // main oscillator with external clock and sub oscillator on: status fills, source switches
    wb(1, 8'h38, 32'h71);
    repeat (600) @(posedge clk_i);
    wb(0, 8'h38, 0);
    chk(q, 32'h71);
    wb(0, 8'h3C, 0);
    chk(q, 32'hFF);
    wb(0, 8'hCC, 0);
    chk(q, 32'h4);
    // pin reset keeps the vector bytes, then the watchdog reset keeps them as well
    for (int k = 0; k < 2; k++) begin
        rnd = xs(rnd);
        vec = rnd[15:0];
        wb(1, 8'hC0, {24'h0, vec[7:0]});
        wb(1, 8'hC4, {24'h0, vec[15:8]});
        if (k == 0) begin
            go <= 1;
            @(posedge clk_i);
            go <= 0;
        end else begin
            wb(1, 8'hC8, 32'h1);
        end
        wait_run(vec);
        chk_defaults();
    end
    wb(0, 8'hC8, 0);
    chk(q, 0);
    wb(0, 8'hCC, 0);
    chk(q, 32'h2);
    results();
end
endmodule
